// File: common/rtccal_defines.svh
// register map, field positions, reset values and timing counts of the calendar block
`ifndef RTCCAL_DEFINES_SVH
`define RTCCAL_DEFINES_SVH

`define RTCCAL_ADDR_WEEKDAY    4'h3
`define RTCCAL_ADDR_DAY        4'h4
`define RTCCAL_ADDR_MONTH      4'h5
`define RTCCAL_ADDR_YEAR       4'h6
`define RTCCAL_ADDR_TRIM       4'h7
`define RTCCAL_ADDR_ALM_MIN    4'h8
`define RTCCAL_ADDR_ALM_HOUR   4'h9
`define RTCCAL_ADDR_ALM_MASK   4'ha

`define RTCCAL_CENTURY_BIT     7
`define RTCCAL_TRIM_INTV_BIT   7
`define RTCCAL_TRIM_DIR_BIT    6
`define RTCCAL_HOUR_PM_BIT     5

`define RTCCAL_TRIM_RESET      8'h00
`define RTCCAL_DAY_RESET       6'h01
`define RTCCAL_MONTH_RESET     5'h01
`define RTCCAL_YEAR_RESET      8'h00
`define RTCCAL_WEEKDAY_RESET   3'h0
`define RTCCAL_WEEKDAY_LAST    3'h6

`define RTCCAL_SEC_BASE_PULSES 16'h8000
`define RTCCAL_FLAG_DELAY_NS   61000
`define RTCCAL_CLK_PERIOD_NS   4

`endif

// File: common/rtccal_pkg.sv
// types shared by the calendar block
package rtccal_pkg;

  typedef enum logic [2:0] {
    RTCCAL_ALM_IDLE = 3'b001,
    RTCCAL_ALM_WAIT = 3'b010,
    RTCCAL_ALM_HOLD = 3'b100
  } rtccal_alm_state_t;

  typedef logic [5:0] rtccal_day_t;
  typedef logic [4:0] rtccal_month_t;
  typedef logic [7:0] rtccal_year_t;

endpackage

// File: common/rtccal_cal_if.sv
// month and year passed to the month-length decoder, last day returned
interface rtccal_cal_if;
  import rtccal_pkg::*;
  rtccal_month_t month;
  rtccal_year_t  year;
  rtccal_day_t   last_day;
  logic          leap;

  modport cal (output month, output year, input last_day, input leap);
  modport lim (input month, input year, output last_day, output leap);
endinterface

// File: design/rtccal_day_limit.sv
// last day of the current month, with leap-year decode
module rtccal_day_limit
  import rtccal_pkg::*;
(
  rtccal_cal_if.lim cal
);

  logic tens_odd;
  logic [3:0] units;

  assign tens_odd = cal.year[4];
  assign units    = cal.year[3:0];

  // year divisible by four in bcd, 00 included
  always_comb begin
    if (tens_odd) begin
      cal.leap = (units == 4'h2) || (units == 4'h6);
    end else begin
      cal.leap = (units == 4'h0) || (units == 4'h4) || (units == 4'h8);
    end
  end

  always_comb begin
    unique case (cal.month)
      5'h02: begin
        cal.last_day = cal.leap ? 6'h29 : 6'h28;
      end
      5'h04, 5'h06, 5'h09, 5'h11: begin
        cal.last_day = 6'h30;
      end
      default: begin
        cal.last_day = 6'h31;
      end
    endcase
  end

endmodule

// File: design/rtccal_top.sv
// calendar counters, time-count trim and weekly alarm compare
`include "rtccal_defines.svh"

module rtccal_top
  import rtccal_pkg::*;
#(
  parameter int FLAG_DELAY_CYC = `RTCCAL_FLAG_DELAY_NS / `RTCCAL_CLK_PERIOD_NS
)
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       osc_32k,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  output logic      [7:0] reg_rdata,
  input  wire logic [6:0] cur_second,
  input  wire logic [6:0] cur_minute,
  input  wire logic [5:0] cur_hour,
  input  wire logic       day_carry,
  input  wire logic       hour_24_mode,
  input  wire logic       power_on_flag,
  input  wire logic       weekly_alarm_enable,
  input  wire logic       weekly_alarm_flag_clear,
  output logic            second_tick,
  output logic            weekly_alarm_flag,
  output logic            alarm_hour_is_pm
);

  // ==========================================================
  // registers
  rtccal_day_t       day_of_month_count;
  rtccal_month_t     month_count;
  logic              century_flag;
  rtccal_year_t      year_count;
  logic [2:0]        weekday_count;
  logic [7:0]        time_count_trim;
  logic [6:0]        weekly_alarm_minute;
  logic [5:0]        weekly_alarm_hour;
  logic [6:0]        weekly_alarm_day_mask;

  logic wr_day;
  logic wr_month;
  logic wr_year;
  logic wr_weekday;
  logic wr_trim;
  logic wr_amin;
  logic wr_ahour;
  logic wr_amask;

  assign wr_weekday = reg_we && (reg_addr == `RTCCAL_ADDR_WEEKDAY);
  assign wr_day     = reg_we && (reg_addr == `RTCCAL_ADDR_DAY);
  assign wr_month   = reg_we && (reg_addr == `RTCCAL_ADDR_MONTH);
  assign wr_year    = reg_we && (reg_addr == `RTCCAL_ADDR_YEAR);
  assign wr_trim    = reg_we && (reg_addr == `RTCCAL_ADDR_TRIM);
  assign wr_amin    = reg_we && (reg_addr == `RTCCAL_ADDR_ALM_MIN);
  assign wr_ahour   = reg_we && (reg_addr == `RTCCAL_ADDR_ALM_HOUR);
  assign wr_amask   = reg_we && (reg_addr == `RTCCAL_ADDR_ALM_MASK);

  // ==========================================================
  // month length
  rtccal_cal_if cal_bus ();

  assign cal_bus.month = month_count;
  assign cal_bus.year  = year_count;

  rtccal_day_limit u_day_limit (
    .cal (cal_bus.lim)
  );

  // ==========================================================
  // calendar counting
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  logic day_wrap;
  logic month_wrap;
  logic year_wrap;
  logic [7:0] day_next8;
  logic [7:0] month_next8;
  logic [7:0] year_next8;

  assign day_wrap    = day_carry && (day_of_month_count == cal_bus.last_day);
  assign month_wrap  = day_wrap && (month_count == 5'h12);
  assign year_wrap   = month_wrap && (year_count == 8'h99);
  assign day_next8   = bcd_inc({2'h0, day_of_month_count});
  assign month_next8 = bcd_inc({3'h0, month_count});
  assign year_next8  = bcd_inc(year_count);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      day_of_month_count <= `RTCCAL_DAY_RESET;
    end else if (wr_day) begin
      day_of_month_count <= reg_wdata[5:0];
    end else if (day_wrap) begin
      day_of_month_count <= 6'h01;
    end else if (day_carry) begin
      day_of_month_count <= day_next8[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      month_count <= `RTCCAL_MONTH_RESET;
    end else if (wr_month) begin
      month_count <= reg_wdata[4:0];
    end else if (month_wrap) begin
      month_count <= 5'h01;
    end else if (day_wrap) begin
      month_count <= month_next8[4:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      year_count <= `RTCCAL_YEAR_RESET;
    end else if (wr_year) begin
      year_count <= reg_wdata;
    end else if (year_wrap) begin
      year_count <= 8'h00;
    end else if (month_wrap) begin
      year_count <= year_next8;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      century_flag <= 1'b0;
    end else if (wr_month) begin
      century_flag <= reg_wdata[`RTCCAL_CENTURY_BIT];
    end else if (year_wrap) begin
      century_flag <= ~century_flag;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      weekday_count <= `RTCCAL_WEEKDAY_RESET;
    end else if (wr_weekday) begin
      weekday_count <= reg_wdata[2:0];
    end else if (day_carry) begin
      if (weekday_count == `RTCCAL_WEEKDAY_LAST) begin
        weekday_count <= 3'h0;
      end else begin
        weekday_count <= weekday_count + 3'h1;
      end
    end
  end

  // ==========================================================
  // trim register and alarm compare registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      time_count_trim <= `RTCCAL_TRIM_RESET;
    end else if (power_on_flag) begin
      time_count_trim <= `RTCCAL_TRIM_RESET;
    end else if (wr_trim) begin
      time_count_trim <= reg_wdata;
    end
  end

  // calendar and alarm contents after power-on are simply kept (undefined)
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      weekly_alarm_minute   <= 7'h00;
      weekly_alarm_hour     <= 6'h00;
      weekly_alarm_day_mask <= 7'h00;
    end else begin
      if (wr_amin) begin
        weekly_alarm_minute <= reg_wdata[6:0];
      end
      if (wr_ahour) begin
        weekly_alarm_hour <= reg_wdata[5:0];
      end
      if (wr_amask) begin
        weekly_alarm_day_mask <= reg_wdata[6:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `RTCCAL_ADDR_WEEKDAY:  reg_rdata <= {5'h00, weekday_count};
        `RTCCAL_ADDR_DAY:      reg_rdata <= {2'h0, day_of_month_count};
        `RTCCAL_ADDR_MONTH:    reg_rdata <= {century_flag, 2'h0, month_count};
        `RTCCAL_ADDR_YEAR:     reg_rdata <= year_count;
        `RTCCAL_ADDR_TRIM:     reg_rdata <= time_count_trim;
        `RTCCAL_ADDR_ALM_MIN:  reg_rdata <= {1'b0, weekly_alarm_minute};
        `RTCCAL_ADDR_ALM_HOUR: reg_rdata <= {2'h0, weekly_alarm_hour};
        `RTCCAL_ADDR_ALM_MASK: reg_rdata <= {1'b0, weekly_alarm_day_mask};
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // oscillator pulse sync and one-second divider
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic osc_rise;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_32k;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  assign osc_rise = osc_s2 && !osc_s3;

  logic       trim_interval_select;
  logic       trim_direction;
  logic [5:0] trim_magnitude;
  logic       adjust_point;
  logic       skip_adjust;
  logic [15:0] trim_delta;
  logic [15:0] sec_len;
  logic [15:0] pulse_cnt;

  assign trim_interval_select = time_count_trim[`RTCCAL_TRIM_INTV_BIT];
  assign trim_direction       = time_count_trim[`RTCCAL_TRIM_DIR_BIT];
  assign trim_magnitude       = time_count_trim[5:0];

  // second value in bcd: 00, 20, 40 or only 00
  assign adjust_point = trim_interval_select ? (cur_second == 7'h00) :
                        ((cur_second == 7'h00) || (cur_second == 7'h20) ||
                         (cur_second == 7'h40));

  always_comb begin
    if (trim_magnitude == 6'h00) begin
      trim_delta = 16'h0000;
    end else if (!trim_direction) begin
      trim_delta = {9'h000, trim_magnitude - 6'h01, 1'b0};
    end else begin
      trim_delta = 16'h0000 - {9'h000, ~trim_magnitude + 6'h01, 1'b0};
    end
  end

  // only the pulse count changes, the oscillator runs untouched
  always_comb begin
    if (adjust_point && !skip_adjust) begin
      sec_len = `RTCCAL_SEC_BASE_PULSES + trim_delta;
    end else begin
      sec_len = `RTCCAL_SEC_BASE_PULSES;
    end
  end

  // a trim write during an adjust-point second arms a skip that lasts until the running second ends
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      skip_adjust <= 1'b0;
    end else if (wr_trim && adjust_point) begin
      skip_adjust <= 1'b1;
    end else if (second_tick) begin
      skip_adjust <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pulse_cnt   <= 16'h0000;
      second_tick <= 1'b0;
    end else begin
      second_tick <= 1'b0;
      if (osc_rise) begin
        if (pulse_cnt >= sec_len - 16'h0001) begin
          pulse_cnt   <= 16'h0000;
          second_tick <= 1'b1;
        end else begin
          pulse_cnt <= pulse_cnt + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // weekly alarm
  logic alarm_match;
  logic alarm_match_d;
  logic day_enabled;
  logic [15:0] delay_cnt;
  rtccal_alm_state_t alm_state;

  assign day_enabled = (weekday_count != 3'h7) &&
                       weekly_alarm_day_mask[weekday_count];
  // raw hour compare covers pm flag and tens-of-twenty alike
  assign alarm_match = (cur_minute == weekly_alarm_minute) &&
                       (cur_hour == weekly_alarm_hour) && day_enabled;
  assign alarm_hour_is_pm = !hour_24_mode &&
                            weekly_alarm_hour[`RTCCAL_HOUR_PM_BIT];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alarm_match_d <= 1'b0;
    end else begin
      alarm_match_d <= alarm_match;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alm_state <= RTCCAL_ALM_IDLE;
      delay_cnt <= 16'h0000;
    end else begin
      unique case (alm_state)
        RTCCAL_ALM_IDLE: begin
          if (alarm_match && !alarm_match_d) begin
            alm_state <= RTCCAL_ALM_WAIT;
            delay_cnt <= 16'h0000;
          end
        end
        RTCCAL_ALM_WAIT: begin
          if (delay_cnt >= 16'(FLAG_DELAY_CYC - 1)) begin
            alm_state <= RTCCAL_ALM_HOLD;
          end else begin
            delay_cnt <= delay_cnt + 16'h0001;
          end
        end
        RTCCAL_ALM_HOLD: begin
          alm_state <= RTCCAL_ALM_IDLE;
        end
        default: begin
          alm_state <= RTCCAL_ALM_IDLE;
        end
      endcase
    end
  end

  // set wins over a clear in the same cycle; disabled alarm reads zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      weekly_alarm_flag <= 1'b0;
    end else if (!weekly_alarm_enable) begin
      weekly_alarm_flag <= 1'b0;
    end else if (alm_state == RTCCAL_ALM_HOLD) begin
      weekly_alarm_flag <= 1'b1;
    end else if (weekly_alarm_flag_clear) begin
      weekly_alarm_flag <= 1'b0;
    end
  end

endmodule

// File: dv/rtccal_asserts.sv
// port-level checks of the calendar, trim and weekly alarm block
`include "rtccal_defines.svh"
module rtccal_asserts #(
  parameter int FLAG_DELAY_CYC = 8
)
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       osc_32k,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic [7:0] reg_rdata,
  input wire logic [6:0] cur_second,
  input wire logic [6:0] cur_minute,
  input wire logic [5:0] cur_hour,
  input wire logic       day_carry,
  input wire logic       hour_24_mode,
  input wire logic       power_on_flag,
  input wire logic       weekly_alarm_enable,
  input wire logic       weekly_alarm_flag_clear,
  input wire logic       second_tick,
  input wire logic       weekly_alarm_flag,
  input wire logic       alarm_hour_is_pm
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence time_moved;
    !$stable(cur_minute) || !$stable(cur_hour);
  endsequence
  sequence no_flag_rise;
    (!$rose(weekly_alarm_flag)) [*8];
  endsequence

  unmapped_zero_a: assert property (
    (reg_addr < 4'h3 || reg_addr > 4'ha) |=> reg_rdata == 8'h00) else $error("unmapped read");
  day_bits_a: assert property (
    reg_addr == `RTCCAL_ADDR_DAY |=> reg_rdata[7:6] == 2'b00 && reg_rdata[5:0] != 6'h00)
    else $error("day read bad");
  month_bits_a: assert property (
    reg_addr == `RTCCAL_ADDR_MONTH |=> reg_rdata[6:5] == 2'b00 && reg_rdata[4:0] != 5'h00)
    else $error("month read bad");
  hour_pm_a: assert property (
    reg_addr == `RTCCAL_ADDR_ALM_HOUR && !reg_we |=> reg_rdata[7:6] == 2'b00
    && (hour_24_mode ? !alarm_hour_is_pm : reg_rdata[5] == alarm_hour_is_pm))
    else $error("alarm hour bit five");
  trim_readback_a: assert property (
    reg_we && reg_addr == `RTCCAL_ADDR_TRIM && !power_on_flag
    ##1 reg_addr == `RTCCAL_ADDR_TRIM && !reg_we && !power_on_flag
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("trim readback");
  trim_cleared_a: assert property (
    power_on_flag && !reg_we ##1 reg_addr == `RTCCAL_ADDR_TRIM && !reg_we
    |=> reg_rdata == 8'h00) else $error("trim not cleared");
  flag_not_early_a: assert property (
    time_moved |=> no_flag_rise) else $error("flag too early");
  flag_sticky_a: assert property (
    weekly_alarm_flag && weekly_alarm_enable && !weekly_alarm_flag_clear
    |=> weekly_alarm_flag || !weekly_alarm_enable) else $error("flag lost");
  flag_disabled_a: assert property (
    !weekly_alarm_enable |=> !weekly_alarm_flag) else $error("flag while disabled");
endmodule

bind rtccal_top rtccal_asserts #(.FLAG_DELAY_CYC(FLAG_DELAY_CYC)) rtccal_asserts_inst (
  .core_clk, .rst_n, .osc_32k, .reg_addr, .reg_wdata, .reg_we, .reg_rdata,
  .cur_second, .cur_minute, .cur_hour, .day_carry, .hour_24_mode, .power_on_flag,
  .weekly_alarm_enable, .weekly_alarm_flag_clear, .second_tick, .weekly_alarm_flag,
  .alarm_hour_is_pm
);

// File: dv/rtccal_host_model.sv
// host side of the register port: byte writes and reads
module rtccal_host_model (
  input  wire logic       core_clk,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_we,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_we    = 1'b0;
  end
  // callers hand over any byte, unused high bits included, which the registers drop
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge core_clk);
    reg_we    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    @(posedge core_clk);
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: dv/rtccal_tb_top.sv
// self-checking bench of the calendar, trim and weekly alarm block
module rtccal_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FD = 8;
  localparam int TRIM_LEN = 32768 - ((6'h3f ^ 6'h3e) + 1) * 2;
  localparam logic [3:0] WA [6] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'h7};
  localparam logic [7:0] WD [6] = '{8'hc5, 8'he9, 8'hd9, 8'hd2, 8'hff, 8'ha5};
  localparam logic [7:0] WR [6] = '{8'h05, 8'h89, 8'h59, 8'h12, 8'h7f, 8'ha5};
  localparam logic [7:0] CD [8] = '{8'h31, 8'h30, 8'h30, 8'h09, 8'h31, 8'h31, 8'h29, 8'h28};
  localparam logic [7:0] CM [8] = '{8'h01, 8'h04, 8'h09, 8'h12, 8'h12, 8'h92, 8'h02, 8'h82};
  localparam logic [7:0] CY [8] = '{8'h23, 8'h23, 8'h45, 8'h50, 8'h99, 8'h99, 8'h00, 8'h97};
  localparam logic [7:0] PH [3] = '{8'h32, 8'h12, 8'h23};
  logic       core_clk, rst_n, osc_32k, day_carry, hour_24_mode, power_on_flag;
  logic       weekly_alarm_enable, weekly_alarm_flag_clear;
  logic       second_tick, weekly_alarm_flag, alarm_hour_is_pm, reg_we;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [6:0] cur_second, cur_minute;
  logic [5:0] cur_hour;
  int         n_errors, n_tests, seed, cyc, k;

  rtccal_top #(.FLAG_DELAY_CYC(FD)) rtccal_top_inst (
    .core_clk, .rst_n, .osc_32k, .reg_addr, .reg_wdata, .reg_we, .reg_rdata,
    .cur_second, .cur_minute, .cur_hour, .day_carry, .hour_24_mode, .power_on_flag,
    .weekly_alarm_enable, .weekly_alarm_flag_clear, .second_tick, .weekly_alarm_flag,
    .alarm_hour_is_pm
  );
  rtccal_host_model rtccal_host_model_inst (
    .core_clk, .reg_addr, .reg_wdata, .reg_we, .reg_rdata
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      conclude();
    end
  end

  // ==========
  // helpers
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    rtccal_host_model_inst.wr(a, d);
  endtask
  task automatic rd_chk(string what, logic [3:0] a, logic [7:0] exp);
    rtccal_host_model_inst.rd(a, v);
    check(what, v, exp);
  endtask
  task automatic carry();
    @(posedge core_clk);
    day_carry <= 1'b1;
    @(posedge core_clk);
    day_carry <= 1'b0;
  endtask
  function automatic logic [7:0] bcd(int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction
  function automatic int bin(logic [7:0] b);
    return b[7:4] * 10 + b[3:0];
  endfunction
  // following date as {month byte, year, day}
  function automatic logic [23:0] next_day(logic [7:0] d, m, y);
    int         dd, mm, yy, last;
    logic       c;
    logic [7:0] t;
    dd = bin(d) + 1;
    mm = bin({3'h0, m[4:0]});
    yy = bin(y);
    c = m[7];
    last = (mm == 4 || mm == 6 || mm == 9 || mm == 11) ? 30 : 31;
    if (mm == 2) last = (yy % 4 == 0) ? 29 : 28;
    if (dd > last) begin
      dd = 1;
      mm++;
    end
    if (mm > 12) begin
      mm = 1;
      yy++;
    end
    if (yy > 99) begin
      yy = 0;
      c = ~c;
    end
    t = bcd(mm);
    return {c, 2'b00, t[4:0], bcd(yy), bcd(dd)};
  endfunction
  task automatic cal(logic [7:0] d, m, y);
    logic [23:0] e;
    e = next_day(d, m, y);
    wr(4'h4, d);
    wr(4'h5, m);
    wr(4'h6, y);
    carry();
    rd_chk("day", 4'h4, e[7:0]);
    rd_chk("month", 4'h5, e[23:16]);
    rd_chk("year", 4'h6, e[15:8]);
  endtask
  task automatic alarm(int w, logic [7:0] mask, logic hit);
    logic [7:0] mn, hr;
    mn = bcd($unsigned($random(seed)) % 60);
    hr = bcd($unsigned($random(seed)) % 24);
    wr(4'ha, 8'h00);
    wr(4'h3, 8'(w));
    wr(4'h8, mn);
    wr(4'h9, hr);
    cur_minute <= mn[6:0];
    cur_hour   <= hr[5:0];
    wr(4'ha, mask);
    repeat (FD) @(posedge core_clk);
    #1;
    check("early flag", weekly_alarm_flag, 1'b0);
    repeat (6) @(posedge core_clk);
    #1;
    check("flag", weekly_alarm_flag, hit);
    weekly_alarm_flag_clear <= 1'b1;
    @(posedge core_clk);
    weekly_alarm_flag_clear <= 1'b0;
    #1;
    check("flag cleared", weekly_alarm_flag, 1'b0);
  endtask

  // ==========
  // main sequence
  initial begin
    seed = 86931;
    {rst_n, osc_32k, day_carry, hour_24_mode, power_on_flag} = 5'h00;
    {weekly_alarm_enable, weekly_alarm_flag_clear} = 2'h0;
    cur_second = 7'h01;
    cur_minute = 7'h00;
    cur_hour   = 6'h00;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk("trim", 4'h7, 8'h00);
    rd_chk("unmapped", 4'hb, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(WA[i], WD[i]);
      rd_chk("masked", WA[i], WR[i]);
    end
    @(posedge core_clk);
    power_on_flag <= 1'b1;
    @(posedge core_clk);
    power_on_flag <= 1'b0;
    rd_chk("trim cleared", 4'h7, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 8; i++) cal(CD[i], CM[i], CY[i]);
    repeat (6) cal(8'h28, 8'h02, bcd($unsigned($random(seed)) % 100));
    wr(4'h3, 8'h06);
    carry();
    rd_chk("weekday", 4'h3, 8'h00);
    $display("test calendar done");
    for (int i = 0; i < 3; i++) begin
      hour_24_mode <= i[1];
      wr(4'h9, PH[i]);
      #1;
      check("pm", alarm_hour_is_pm, i == 0);
    end
    weekly_alarm_enable <= 1'b1;
    for (int w = 0; w < 7; w++) begin
      alarm(w, 8'h01 << w, 1'b1);
      alarm(w, 8'h7f ^ (8'h01 << w), 1'b0);
    end
    alarm(2, 8'h00, 1'b0);
    // flag raised, then dropped by the enable going low
    wr(4'ha, 8'h7f);
    repeat (FD + 6) @(posedge core_clk);
    #1;
    check("flag set", weekly_alarm_flag, 1'b1);
    weekly_alarm_enable <= 1'b0;
    @(posedge core_clk);
    #1;
    check("flag disabled", weekly_alarm_flag, 1'b0);
    $display("test alarm done");
    wr(4'h7, 8'hfe);
    cur_second <= 7'h00;
    k = 0;
    while (second_tick !== 1'b1 && k < 33000) begin
      @(posedge core_clk);
      osc_32k <= ~osc_32k;
      if (osc_32k === 1'b0) k++;
    end
    check("second", k > TRIM_LEN && k < TRIM_LEN + 4, 1'b1);
    $display("test trim done");
    conclude();
  end
endmodule
